// [bag_core.sv]
// Bit address generator and address register sizing unit, AHB-Lite slave
// Operation
// - Register direct picks one bit, position zero to seven, of a byte reg.
// - Address register as register-direct target exposes only its low byte.
// - Absolute counts bits from base; short form below 10000, long 1000000.
// - Indirect counts bits from the byte the address register points at.
// - Register relative: base is bit address, register value the bit offset.
// - Register and static relative sums wrap to zero past top address.
// - Register relative reach is 256, 65536 or 16777216 bytes by form.
// - Static relative adds base unsigned to static base, then bit offset.
// - Static relative reach is 256 or 65536 bytes by form.
// - Frame relative adds base signed; overflow wraps at 24-bit byte range.
// - Frame relative reach is -128..127 or -32768..32767 bytes.
// - Flag direct selects one of eight flags, only for flag clear/set.
// - Byte read of address register uses low eight bits, 8-bit flags.
// - Byte transfer to address register zero-extends to 16, clears top.
// - Byte arithmetic on address register computes in 16, clears top.
// - Word read of address register uses low 16 bits, 16-bit flags.
// - Word write loads low 16 bits, clears top eight, 16-bit flags.
// - Long read presents register zero-extended to 32, 32-bit flags.
// - Long write keeps low 24 bits; sign from bit 31 of full value.
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module bag_core (
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [bag_pkg::DATA_W-1:0] hwdata,
    input  wire logic                    hready,
    output logic      [bag_pkg::DATA_W-1:0] hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic      [bag_pkg::ADDR_W-1:0] ea_addr,
    output logic      [2:0]              ea_bit,
    output logic                         ea_mem,
    output logic      [7:0]              flag_onehot,
    output logic                         flag_err
);
    import bag_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    logic        wr_pend_q;
    logic [7:0]  waddr_q;
    logic [31:0] rdata_q;
    logic [31:0] rd_mux;
    logic        take;
    logic        hsize_word;

    // Narrower sizes are not refused; every access is treated as a word
    assign hsize_word = (hsize == 3'h2);
    assign take       = hsel & hready & htrans[1];
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = rdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            waddr_q   <= 8'h00;
            rdata_q   <= RST_WORD;
        end else begin
            wr_pend_q <= take & hwrite & (hsize_word | ~hsize_word);
            if (take) begin
                waddr_q <= haddr[OFFS_W-1:0];
            end
            if (take & ~hwrite) begin
                rdata_q <= rd_mux;
            end
        end
    end

    function automatic logic wr_hit(input logic [7:0] off);
        wr_hit = wr_pend_q && (waddr_q == off);
    endfunction

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    bag_bit_ctrl_type ctrl_q;
    logic [26:0]      base_q;
    logic [23:0]      areg0_q;
    logic [23:0]      areg1_q;
    logic [23:0]      sbase_q;
    logic [23:0]      fbase_q;
    logic [15:0]      gp0_q;
    logic [15:0]      gp1_q;
    logic [31:0]      sz_src_q;
    logic [31:0]      sz_res_q;
    logic             sz_s_q;
    logic             sz_z_q;
    bag_sz_ctrl_type  sz_ctrl_q;
    bag_ea_type       ea_q;
    logic [7:0]       onehot_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q  <= bag_bit_ctrl_type'(RST_WORD[CTRL_W-1:0]);
            base_q  <= RST_WORD[26:0];
            sbase_q <= RST_WORD[23:0];
            fbase_q <= RST_WORD[23:0];
            gp0_q   <= RST_WORD[15:0];
            gp1_q   <= RST_WORD[15:0];
        end else begin
            ctrl_q  <= wr_hit(OFF_BIT_CTRL)
                     ? bag_bit_ctrl_type'(hwdata[CTRL_W-1:0]) : ctrl_q;
            base_q  <= wr_hit(OFF_BASE)  ? hwdata[26:0] : base_q;
            sbase_q <= wr_hit(OFF_SBASE) ? hwdata[23:0] : sbase_q;
            fbase_q <= wr_hit(OFF_FBASE) ? hwdata[23:0] : fbase_q;
            gp0_q   <= wr_hit(OFF_GP0)   ? hwdata[15:0] : gp0_q;
            gp1_q   <= wr_hit(OFF_GP1)   ? hwdata[15:0] : gp1_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sz_src_q <= RST_WORD;
        end else if (wr_hit(OFF_SZ_SRC)) begin
            sz_src_q <= hwdata;
        end
    end

    // ------------------------------------------------------------------
    // Address register sizing
    // ------------------------------------------------------------------
    bag_sz_ctrl_type sz_cmd;
    logic            sz_go;
    logic [23:0]     sz_a;
    logic [15:0]     v16;
    logic [31:0]     v32;
    logic [31:0]     sz_res;
    logic [23:0]     a_new;
    logic            a_wr;
    logic            sz_ok;
    logic            s_flag;
    logic            z_flag;

    // A command write acts at once, so it can follow any register write
    assign sz_cmd = bag_sz_ctrl_type'(hwdata[SZC_W-1:0]);
    // Spelled out: an assign calling wr_hit would never see its state change
    assign sz_go  = wr_pend_q && (waddr_q == OFF_SZ_CTRL);
    assign sz_a   = sz_cmd.areg_sel ? areg1_q : areg0_q;
    assign sz_ok  = (sz_cmd.size != 2'h3) && (sz_cmd.op != 2'h3);

    always_comb begin
        v16    = 16'h0000;
        v32    = 32'h0000_0000;
        sz_res = 32'h0000_0000;
        a_new  = sz_a;
        a_wr   = 1'b0;
        s_flag = 1'b0;
        z_flag = 1'b0;
        if (sz_cmd.op == OP_READ) begin
            unique case (sz_cmd.size)
                SZ_B: begin
                    sz_res = {24'h000000, sz_a[7:0]};
                    s_flag = sz_a[7];
                    z_flag = (sz_a[7:0] == 8'h00);
                end
                SZ_W: begin
                    sz_res = {16'h0000, sz_a[15:0]};
                    s_flag = sz_a[15];
                    z_flag = (sz_a[15:0] == 16'h0000);
                end
                SZ_L: begin
                    sz_res = {8'h00, sz_a};
                    s_flag = 1'b0;
                    z_flag = (sz_a == 24'h000000);
                end
                default: sz_res = 32'h0000_0000;
            endcase
        end else if (sz_cmd.size == SZ_L) begin
            // Top byte is lost in the register but still seen by the flags
            v32    = (sz_cmd.op == OP_MOVE) ? sz_src_q
                                            : {8'h00, sz_a} + sz_src_q;
            sz_res = v32;
            a_new  = v32[23:0];
            a_wr   = sz_ok;
            s_flag = v32[31];
            z_flag = (v32 == 32'h0000_0000);
        end else begin
            v16 = (sz_cmd.size == SZ_B) ? {8'h00, sz_src_q[7:0]}
                                        : sz_src_q[15:0];
            if (sz_cmd.op == OP_ADD) begin
                v16 = v16 + sz_a[15:0];
            end
            sz_res = {16'h0000, v16};
            a_new  = {8'h00, v16};
            a_wr   = sz_ok;
            s_flag = v16[15];
            z_flag = (v16 == 16'h0000);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            areg0_q <= RST_WORD[23:0];
            areg1_q <= RST_WORD[23:0];
        end else begin
            if (wr_hit(OFF_AREG0)) begin
                areg0_q <= hwdata[23:0];
            end else if (sz_go && a_wr && !sz_cmd.areg_sel) begin
                areg0_q <= a_new;
            end
            if (wr_hit(OFF_AREG1)) begin
                areg1_q <= hwdata[23:0];
            end else if (sz_go && a_wr && sz_cmd.areg_sel) begin
                areg1_q <= a_new;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sz_res_q  <= RST_WORD;
            sz_s_q    <= 1'b0;
            sz_z_q    <= 1'b0;
            sz_ctrl_q <= bag_sz_ctrl_type'(RST_WORD[SZC_W-1:0]);
        end else if (sz_go && sz_ok) begin
            sz_res_q  <= sz_res;
            sz_s_q    <= s_flag;
            sz_z_q    <= z_flag;
            sz_ctrl_q <= sz_cmd;
        end
    end

    // ------------------------------------------------------------------
    // Bit address generation
    // ------------------------------------------------------------------
    logic [23:0] ar;
    logic [26:0] form_mask;
    logic [26:0] base27;
    logic [26:0] base_sext;
    logic [26:0] bit_addr;
    logic [7:0]  dir_byte;
    bag_ea_type  ea_d;

    assign ar = ctrl_q.areg_sel ? areg1_q : areg0_q;
    always_comb begin
        unique case (ctrl_q.form)
            FORM_11: form_mask = MASK_11;
            FORM_19: form_mask = MASK_19;
            FORM_27: form_mask = MASK_27;
            default: form_mask = MASK_27;
        endcase
    end

    assign base27    = base_q & form_mask;
    assign base_sext = (ctrl_q.form == FORM_11)
                     ? {{16{base_q[10]}}, base_q[10:0]}
                     : {{8{base_q[18]}}, base_q[18:0]};

    always_comb begin
        unique case (ctrl_q.reg_sel)
            SEL_GP0L:  dir_byte = gp0_q[7:0];
            SEL_GP0H:  dir_byte = gp0_q[15:8];
            SEL_GP1L:  dir_byte = gp1_q[7:0];
            SEL_GP1H:  dir_byte = gp1_q[15:8];
            SEL_AREG0: dir_byte = areg0_q[7:0];
            SEL_AREG1: dir_byte = areg1_q[7:0];
            default:   dir_byte = 8'h00;
        endcase
    end

    always_comb begin
        bit_addr = 27'h0000000;
        unique case (ctrl_q.mode)
            MODE_ABS: begin
                // Short form has no 11-bit variant, so only two reaches
                bit_addr = base_q & ((ctrl_q.form == FORM_27) ? MASK_27
                                                              : MASK_19);
            end
            MODE_IND: bit_addr = {ar, base_q[2:0]};
            MODE_AREL: bit_addr = base27 + {3'h0, ar};
            MODE_SBREL: begin
                bit_addr = {sbase_q, 3'h0}
                         + (base_q & ((ctrl_q.form == FORM_11) ? MASK_11
                                                               : MASK_19));
            end
            MODE_FBREL: bit_addr = {fbase_q, 3'h0} + base_sext;
            default: bit_addr = {24'h000000, base_q[2:0]};
        endcase
    end

    always_comb begin
        ea_d          = '0;
        ea_d.addr     = bit_addr[26:3];
        ea_d.bit_idx  = bit_addr[2:0];
        ea_d.mem      = (ctrl_q.mode >= MODE_ABS) && (ctrl_q.mode <= MODE_FBREL);
        ea_d.bit_val  = dir_byte[base_q[2:0]];
        if (ctrl_q.mode == MODE_REGDIR || ctrl_q.mode == MODE_FLAG) begin
            ea_d.addr = 24'h000000;
        end
        if (ctrl_q.mode == MODE_FLAG) begin
            ea_d.bit_idx  = ctrl_q.flag_sel;
            ea_d.flag_err = ~ctrl_q.flag_instr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ea_q     <= bag_ea_type'(RST_WORD[29:0]);
            onehot_q <= 8'h00;
        end else begin
            ea_q     <= ea_d;
            onehot_q <= (ctrl_q.mode == MODE_FLAG && ctrl_q.flag_instr)
                      ? (8'h01 << ctrl_q.flag_sel) : 8'h00;
        end
    end

    assign ea_addr     = ea_q.addr;
    assign ea_bit      = ea_q.bit_idx;
    assign ea_mem      = ea_q.mem;
    assign flag_err    = ea_q.flag_err;
    assign flag_onehot = onehot_q;

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------
    always_comb begin
        unique case (haddr[OFFS_W-1:0])
            OFF_BIT_CTRL: rd_mux = {19'h00000, ctrl_q};
            OFF_BASE:     rd_mux = {5'h00, base_q};
            OFF_AREG0:    rd_mux = {8'h00, areg0_q};
            OFF_AREG1:    rd_mux = {8'h00, areg1_q};
            OFF_SBASE:    rd_mux = {8'h00, sbase_q};
            OFF_FBASE:    rd_mux = {8'h00, fbase_q};
            OFF_GP0:      rd_mux = {16'h0000, gp0_q};
            OFF_GP1:      rd_mux = {16'h0000, gp1_q};
            OFF_EA:       rd_mux = {2'h0, ea_q};
            OFF_SZ_CTRL:  rd_mux = {27'h0000000, sz_ctrl_q};
            OFF_SZ_SRC:   rd_mux = sz_src_q;
            OFF_SZ_RES:   rd_mux = sz_res_q;
            OFF_SZ_FLAGS: rd_mux = {30'h00000000, sz_s_q, sz_z_q};
            OFF_FLAG_SEL: rd_mux = {23'h000000, ea_q.flag_err, onehot_q};
            default:      rd_mux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [2:0] mode_now;
    assign mode_now = ctrl_q.mode;

    regdir_bit_a: assert property ((mode_now == MODE_REGDIR) |=>
        (!ea_mem && ea_addr == 24'h000000 && ea_bit == $past(base_q[2:0])))
        else $error("register direct bit position wrong");
    areg_byte_a: assert property (
        (mode_now == MODE_REGDIR && ctrl_q.reg_sel == SEL_AREG0)
        |=> (ea_q.bit_val == $past(areg0_q[base_q[2:0]])))
        else $error("address register bit not from low byte");
    abs_range_a: assert property (
        (mode_now == MODE_ABS && ctrl_q.form != FORM_27)
        |=> (ea_addr[23:16] == 8'h00 && ea_mem))
        else $error("short absolute address out of range");
    ind_addr_a: assert property (
        (mode_now == MODE_IND && !ctrl_q.areg_sel)
        |=> (ea_addr == $past(areg0_q) && ea_bit == $past(base_q[2:0])))
        else $error("indirect address wrong");
    arel_sum_a: assert property (
        (mode_now == MODE_AREL && ctrl_q.form == FORM_27 && !ctrl_q.areg_sel)
        |=> ({ea_addr, ea_bit} == 27'($past(base_q) + $past(areg0_q))))
        else $error("register relative sum wrong");
    sb_reach_a: assert property (
        (mode_now == MODE_SBREL && ctrl_q.form == FORM_11)
        |=> ({ea_addr, ea_bit} - {$past(sbase_q), 3'h0} <= 27'h00007ff))
        else $error("static relative reach exceeded");
    fb_reach_a: assert property (
        (mode_now == MODE_FBREL && ctrl_q.form == FORM_11)
        |=> (24'(ea_addr - $past(fbase_q) + 24'h000080) <= 24'h0000ff))
        else $error("frame relative reach exceeded");
    flag_sel_a: assert property (
        ##1 ($countones(flag_onehot) == 1) |->
        ($past(ctrl_q.flag_instr) && flag_onehot[ea_bit] && !ea_mem))
        else $error("flag select not one of eight");
    sz_byte_read_a: assert property (
        (sz_go && sz_cmd.op == OP_READ && sz_cmd.size == SZ_B)
        |=> (sz_res_q[31:8] == 24'h000000 && sz_z_q == (sz_res_q == 0)))
        else $error("byte read of address register wrong");
    sz_word_write_a: assert property (
        (sz_go && sz_cmd.op == OP_MOVE && sz_cmd.size == SZ_W
         && !sz_cmd.areg_sel)
        |=> (areg0_q == {8'h00, $past(sz_src_q[15:0])}))
        else $error("word write did not clear top byte");
    sz_long_write_a: assert property (
        (sz_go && sz_cmd.op == OP_MOVE && sz_cmd.size == SZ_L
         && !sz_cmd.areg_sel)
        |=> (areg0_q == $past(sz_src_q[23:0])
             && sz_s_q == $past(sz_src_q[31])))
        else $error("long write flags or value wrong");

endmodule

`default_nettype wire

// [bag_core_tb.sv]
// Self-checking testbench of the bit address generator
`timescale 1ns/100ps
`default_nettype none

module bag_core_tb;
    import bag_pkg::*;
    localparam logic [31:0] MM = 32'h0fffffff;
    localparam logic [31:0] MR = 32'h1fffffff;
    localparam logic [31:0] MF = 32'hffffffff;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rd;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire  [23:0] ea_addr;
    wire  [7:0]  flag_onehot;
    wire  [2:0]  ea_bit;
    wire         ea_mem;
    wire         flag_err;
    wire         hresp;
    int          fail_count = 0;
    int          cmp_count = 0;

    bag_core uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .ea_addr(ea_addr), .ea_bit(ea_bit), .ea_mem(ea_mem),
        .flag_onehot(flag_onehot), .flag_err(flag_err)
    );

    always #2 hclk = ~hclk;

    // ----------
    // Bus tasks
    // ----------
    task automatic chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            $display("unexpected %s exp %h got %h", n, e, g);
            fail_count++;
        end
    endtask

    // Entered just after an edge; leaves just after the data phase edge
    task automatic xfer(input logic [7:0] a, input logic w, logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    // Idle first: derived outputs trail a register write by one edge
    task automatic rchk(input string n, input logic [7:0] a,
                        input logic [31:0] e, m);
        repeat (2) @(posedge hclk);
        xfer(a, 1'b0, 32'h0);
        chk(n, e, rd & m);
    endtask

    function automatic logic [31:0] mk(input logic [2:0] m,
        input logic [1:0] f, input logic s, input logic [2:0] r);
        return {23'h0, r, s, f, m};
    endfunction

    task automatic ea(input logic [31:0] c, e, m);
        xfer(OFF_BIT_CTRL, 1'b1, c);
        rchk("ea", OFF_EA, e, m);
        chk("ea_pins", {4'h0, e[27:0]}, {4'h0, ea_mem, ea_bit, ea_addr});
    endtask

    task automatic sz(input logic [31:0] a0, s, c, ea, er, ef);
        logic [7:0] ar;
        ar = c[4] ? OFF_AREG1 : OFF_AREG0;
        xfer(ar, 1'b1, a0);
        xfer(OFF_SZ_SRC, 1'b1, s);
        xfer(OFF_SZ_CTRL, 1'b1, c);
        rchk("areg", ar, ea, MF);
        rchk("res", OFF_SZ_RES, er, MF);
        rchk("flags", OFF_SZ_FLAGS, ef, MF);
    endtask

    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ----------
    // Tests
    // ----------
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk("ea", OFF_EA, 32'h0, MF);
        rchk("hole", 8'h38, 32'h0, MF);
        chk("hresp", 32'h0, {31'h0, hresp});
        $display("reset done");
        xfer(OFF_BASE, 1'b1, 32'h07ffffff);
        ea(mk(MODE_ABS, FORM_19, 1'b0, 3'h0), 32'h0f00ffff, MM);
        ea(mk(MODE_ABS, FORM_27, 1'b0, 3'h0), 32'h0fffffff, MM);
        xfer(OFF_AREG0, 1'b1, 32'h1);
        ea(mk(MODE_AREL, FORM_11, 1'b0, 3'h0), 32'h08000100, MM);
        ea(mk(MODE_AREL, FORM_19, 1'b0, 3'h0), 32'h08010000, MM);
        ea(mk(MODE_AREL, FORM_27, 1'b0, 3'h0), 32'h08000000, MM);
        xfer(OFF_SBASE, 1'b1, 32'h00ffffff);
        ea(mk(MODE_SBREL, FORM_11, 1'b0, 3'h0), 32'h0f0000fe, MM);
        ea(mk(MODE_SBREL, FORM_19, 1'b0, 3'h0), 32'h0f00fffe, MM);
        xfer(OFF_BASE, 1'b1, 32'h8);
        ea(mk(MODE_SBREL, FORM_11, 1'b0, 3'h0), 32'h08000000, MM);
        xfer(OFF_BASE, 1'b1, 32'h7f8);
        ea(mk(MODE_FBREL, FORM_11, 1'b0, 3'h0), 32'h08ffffff, MM);
        xfer(OFF_BASE, 1'b1, 32'h3ff);
        ea(mk(MODE_FBREL, FORM_11, 1'b0, 3'h0), 32'h0f00007f, MM);
        xfer(OFF_FBASE, 1'b1, 32'h10000);
        xfer(OFF_BASE, 1'b1, 32'h40000);
        ea(mk(MODE_FBREL, FORM_19, 1'b0, 3'h0), 32'h08008000, MM);
        xfer(OFF_AREG1, 1'b1, 32'habcdef);
        xfer(OFF_BASE, 1'b1, 32'h5);
        ea(mk(MODE_IND, FORM_11, 1'b1, 3'h0), 32'h0dabcdef, MM);
        $display("memory forms done");
        xfer(OFF_BASE, 1'b1, 32'ha);
        xfer(OFF_AREG0, 1'b1, 32'hffff5a);
        ea(mk(MODE_REGDIR, FORM_11, 1'b0, SEL_AREG0), 32'h02000000, MR);
        xfer(OFF_AREG0, 1'b1, 32'ha5);
        ea(mk(MODE_REGDIR, FORM_11, 1'b0, SEL_AREG0), 32'h12000000, MR);
        xfer(OFF_GP0, 1'b1, 32'h0400);
        ea(mk(MODE_REGDIR, FORM_11, 1'b0, SEL_GP0H), 32'h12000000, MR);
        for (int i = 0; i < 8; i++) begin
            xfer(OFF_BIT_CTRL, 1'b1, {20'h1, i[2:0], 6'h0, MODE_FLAG});
            rchk("flag", OFF_FLAG_SEL, 32'h1 << i, MF);
        end
        chk("onehot", 32'h80, {24'h0, flag_onehot});
        xfer(OFF_BIT_CTRL, 1'b1, {20'h0, 3'h2, 6'h0, MODE_FLAG});
        rchk("flag", OFF_FLAG_SEL, 32'h100, MF);
        chk("flag_err", 32'h1, {31'h0, flag_err});
        $display("register and flag done");
        sz(32'h1234f6, 0, {28'h0, OP_READ, SZ_B}, 32'h1234f6, 32'hf6, 2);
        sz(32'h1234f6, 0, {28'h0, OP_READ, SZ_W}, 32'h1234f6, 32'h34f6, 0);
        sz(32'h1234f6, 0, {28'h0, OP_READ, SZ_L}, 32'h1234f6, 32'h1234f6, 0);
        sz(32'hffffff, 32'hffffff80, {28'h1, OP_MOVE, SZ_B}, 32'h80, 32'h80, 0);
        sz(32'hfffff0, 32'h10, {28'h1, OP_ADD, SZ_B}, 0, 0, 1);
        sz(32'hffffff, 32'h12348000, {28'h0, OP_MOVE, SZ_W}, 32'h8000, 32'h8000, 2);
        sz(32'hffffff, 32'h80000000, {28'h1, OP_MOVE, SZ_L}, 0, 32'h80000000, 2);
        xfer(OFF_SZ_CTRL, 1'b1, 32'h3);
        rchk("szc", OFF_SZ_CTRL, {28'h1, OP_MOVE, SZ_L}, MF);
        $display("sizing done");
        finish_test;
    end

    // Whole run needs well under 5000 cycles
    initial begin
        #80000;
        fail_count++;
        finish_test;
    end
endmodule

`default_nettype wire

// [bag_pkg.sv]
// Constants, register map and carrier types of the bit address generator
package bag_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int ADDR_W = 24;
    localparam int BITA_W = 27;
    localparam int OFFS_W = 8;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_BIT_CTRL  = 8'h00;
    localparam logic [7:0] OFF_BASE      = 8'h04;
    localparam logic [7:0] OFF_AREG0     = 8'h08;
    localparam logic [7:0] OFF_AREG1     = 8'h0c;
    localparam logic [7:0] OFF_SBASE     = 8'h10;
    localparam logic [7:0] OFF_FBASE     = 8'h14;
    localparam logic [7:0] OFF_GP0       = 8'h18;
    localparam logic [7:0] OFF_GP1       = 8'h1c;
    localparam logic [7:0] OFF_EA        = 8'h20;
    localparam logic [7:0] OFF_SZ_CTRL   = 8'h24;
    localparam logic [7:0] OFF_SZ_SRC    = 8'h28;
    localparam logic [7:0] OFF_SZ_RES    = 8'h2c;
    localparam logic [7:0] OFF_SZ_FLAGS  = 8'h30;
    localparam logic [7:0] OFF_FLAG_SEL  = 8'h34;

    // ------------------------------------------------------------------
    // Reset value and field codes
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam int CTRL_W = 13;
    localparam int SZC_W  = 5;

    localparam logic [2:0] MODE_REGDIR = 3'h0;
    localparam logic [2:0] MODE_ABS    = 3'h1;
    localparam logic [2:0] MODE_IND    = 3'h2;
    localparam logic [2:0] MODE_AREL   = 3'h3;
    localparam logic [2:0] MODE_SBREL  = 3'h4;
    localparam logic [2:0] MODE_FBREL  = 3'h5;
    localparam logic [2:0] MODE_FLAG   = 3'h6;

    localparam logic [1:0] FORM_11 = 2'h0;
    localparam logic [1:0] FORM_19 = 2'h1;
    localparam logic [1:0] FORM_27 = 2'h2;

    localparam logic [26:0] MASK_11 = 27'h00007ff;
    localparam logic [26:0] MASK_19 = 27'h007ffff;
    localparam logic [26:0] MASK_27 = 27'h7ffffff;

    localparam logic [2:0] SEL_GP0L  = 3'h0;
    localparam logic [2:0] SEL_GP0H  = 3'h1;
    localparam logic [2:0] SEL_GP1L  = 3'h2;
    localparam logic [2:0] SEL_GP1H  = 3'h3;
    localparam logic [2:0] SEL_AREG0 = 3'h4;
    localparam logic [2:0] SEL_AREG1 = 3'h5;

    localparam logic [1:0] SZ_B = 2'h0;
    localparam logic [1:0] SZ_W = 2'h1;
    localparam logic [1:0] SZ_L = 2'h2;

    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_MOVE = 2'h1;
    localparam logic [1:0] OP_ADD  = 2'h2;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       flag_instr;
        logic [2:0] flag_sel;
        logic [2:0] reg_sel;
        logic       areg_sel;
        logic [1:0] form;
        logic [2:0] mode;
    } bag_bit_ctrl_type;

    typedef struct packed {
        logic       areg_sel;
        logic [1:0] op;
        logic [1:0] size;
    } bag_sz_ctrl_type;

    typedef struct packed {
        logic        flag_err;
        logic        bit_val;
        logic        mem;
        logic [2:0]  bit_idx;
        logic [23:0] addr;
    } bag_ea_type;

endpackage
